// [tb_tcc_timer_cc.sv]
// self-checking bench for the timer capture/compare channels
`timescale 1ns/1ns
`default_nettype none
module tb_tcc_timer_cc;
  import tcc_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0;
  logic [1:0] pins = 0; // levels asked of the pin model
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0] bresp, rresp, cc_in, cc_out;
  wire logic [31:0] rdata;
  int failures = 0, n_checks = 0;
  logic [1:0] wresp = 0; // response code of the last write
  always #5 aclk = ~aclk;
  // responses are always accepted, so ready is tied high
  tcc_timer_cc tcc_timer_cc_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .cc_in(cc_in), .cc_out(cc_out), .irq(irq));
  tcc_pin_model tcc_pin_model_inst (.aclk(aclk), .aresetn(aresetn),
    .want(pins), .cc_in(cc_in));
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // each request stands until the edge at which its ready is seen high
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic a, w;
    a = 0;
    w = 0;
    awaddr <= {2'h0, i, 2'h0};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (!a && awready) begin
        a = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    wresp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk("rdata", e, d);
    chk("rresp", 32'h0, {30'h0, r});
  endtask : rchk
  // bounded wait for an output pin level
  task automatic wait_pin(input logic v, input int c = 0);
    for (int n = 0; n < 60 && cc_out[c] !== v; n++) @(negedge aclk);
    chk("cc_out", {31'h0, v}, {31'h0, cc_out[c]});
    @(posedge aclk);
  endtask : wait_pin
  task automatic t_reset;
    rchk(TCC_IDX_CH1_CTL, 32'h40);
    rchk(TCC_IDX_CH2_CTL, 32'h40);
    rchk(TCC_IDX_CH1_LO, 32'h0);
    rchk(TCC_IDX_CH2_HI, 32'h0);
  endtask : t_reset
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    wr(TCC_IDX_CH1_HI, 32'hA5);
    chk("bresp", 32'h0, {30'h0, wresp});
    rchk(TCC_IDX_CH1_HI, 32'hA5);
    wr(TCC_IDX_CH1_HI, 32'h0);
    wr(8'h00, 32'h0); // unmapped place
    chk("bresp", {30'h0, TCC_RESP_SLVERR}, {30'h0, wresp});
    rd(8'h00, d, r); // unmapped place
    chk("rresp", {30'h0, TCC_RESP_SLVERR}, {30'h0, r});
  endtask : t_regs
  // modulo 0..20, ch1 matches at 5; reserved bit always written 0
  task automatic t_compare;
    wr(TCC_IDX_CH0_CMP, 32'h14);
    wr(TCC_IDX_CH1_LO, 32'h5);
    wr(TCC_IDX_CH1_CTL, 32'h44);
    wr(TCC_IDX_TCTL, 32'h2);
    wait_pin(1'b1);
    rchk(TCC_IDX_TCTL, 32'h42);
    chk("irq", 32'h1, {31'h0, irq});
    wr(TCC_IDX_CH1_CTL, 32'h4C);
    wait_pin(1'b0);
    wr(TCC_IDX_TCTL, 32'h40);
    rchk(TCC_IDX_TCTL, 32'h40);
    wr(TCC_IDX_TCTL, 32'h0);
    rchk(TCC_IDX_TCTL, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(TCC_IDX_CH1_CTL, 32'h54);
    wr(TCC_IDX_TCTL, 32'h2);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wr(TCC_IDX_CH1_CTL, 32'h04);
    wait_pin(1'b1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(TCC_IDX_TCTL, 32'h0);
  endtask : t_compare
  // stopped count is at most 20, so a capture clears the high byte
  task automatic t_capture;
    wr(TCC_IDX_CH2_HI, 32'hFF);
    wr(TCC_IDX_CH2_CTL, 32'h42);
    pins <= 2'h2;
    repeat (4) @(posedge aclk);
    rchk(TCC_IDX_TCTL, 32'h0);
    pins <= 2'h0;
    repeat (4) @(posedge aclk);
    rchk(TCC_IDX_TCTL, 32'h80);
    chk("irq", 32'h1, {31'h0, irq});
    rchk(TCC_IDX_CH2_HI, 32'h0);
  endtask : t_capture
  // ch2 code 101 in modulo, then ch1 110 and ch2 011 in up/down
  task automatic t_pair;
    wr(TCC_IDX_CH2_LO, 32'h8);
    wr(TCC_IDX_CH2_CTL, 32'h2C);
    wr(TCC_IDX_TCTL, 32'h2);
    wait_pin(1'b1, 1);
    wait_pin(1'b0, 1);
    wr(TCC_IDX_CH1_CTL, 32'h34);
    wr(TCC_IDX_CH2_CTL, 32'h1C);
    wr(TCC_IDX_TCTL, 32'h3);
    wait_pin(1'b0);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1, 1);
    wait_pin(1'b0, 1);
    wr(TCC_IDX_TCTL, 32'h0);
  endtask : t_pair
  task complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset;
    t_regs;
    t_compare;
    t_capture;
    t_pair;
    complete_run;
  end
endmodule : tb_tcc_timer_cc
`default_nettype wire

// [tcc_chan.sv]
// one capture/compare channel: output action and input edge capture
`timescale 1ns/1ns
`default_nettype none
module tcc_chan
  import tcc_pkg::*;
#(
  parameter int W = TCC_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] ctl,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] pair_value,
  input wire logic running,
  input wire logic updown,
  input wire logic down,
  input wire logic pin_in,
  output logic pin_out_ff,
  output logic cap_evt,
  output logic cmp_evt
);

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  wire is_cmp = ctl[TCC_CTL_FUNC_BIT];
  wire [2:0] cmp_code = ctl[TCC_CTL_CMP_LSB +: 3];
  wire [1:0] cap_sel = ctl[TCC_CTL_CAP_LSB +: 2];
  // hits only while the counter runs, so a held count fires no repeats
  wire own_hit = running & (count == value);
  wire pair_hit = running & (count == pair_value);
  wire zero_hit = running & (count == {W{1'b0}});
  logic pin_prev_ff; // last sampled input level
  wire rise = pin_in & ~pin_prev_ff;
  wire fall = ~pin_in & pin_prev_ff;
  wire cap_rise = (cap_sel == TCC_CAP_RISE) | (cap_sel == TCC_CAP_BOTH);
  wire cap_fall = (cap_sel == TCC_CAP_FALL) | (cap_sel == TCC_CAP_BOTH);

  // capture on the selected edge, in capture mode only
  assign cap_evt = ~is_cmp & ((cap_rise & rise) | (cap_fall & fall));
  assign cmp_evt = is_cmp & own_hit;

  ////////////////////////////////////////////////////////////////////////////
  // output action per compare code; own match wins a tie with ch0 match
  function automatic logic out_next(input logic [2:0] code,
                                    input logic cur, input logic own,
                                    input logic pair, input logic zero,
                                    input logic updn, input logic dn);
    logic r;
    r = cur;
    case (code)
      TCC_CMP_SET: r = own ? 1'b1 : cur;
      TCC_CMP_CLR: r = own ? 1'b0 : cur;
      TCC_CMP_TOG: r = own ? ~cur : cur;
      // set going up; clear at zero, or going down in up/down
      TCC_CMP_UPSET: r = updn ? (own ? ~dn : cur)
                              : (own ? 1'b1 : (zero ? 1'b0 : cur));
      // clear going up; set at zero, or going down in up/down
      TCC_CMP_UPCLR: r = updn ? (own ? dn : cur)
                              : (own ? 1'b0 : (zero ? 1'b1 : cur));
      // paired with the ch0 compare value
      TCC_CMP_PAIR_CS: r = own ? 1'b1 : (pair ? 1'b0 : cur);
      // paired with the ch0 compare value
      TCC_CMP_PAIR_SC: r = own ? 1'b0 : (pair ? 1'b1 : cur);
      default: r = cur; // unused code holds the pin
    endcase
    return r;
  endfunction : out_next

  wire nxt_pin_out = is_cmp ? out_next(cmp_code, pin_out_ff, own_hit,
                                       pair_hit, zero_hit, updown, down)
                            : pin_out_ff;

  // pin output and input history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_prev_ff <= pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CMP_SET: assert property (
    is_cmp && cmp_code == TCC_CMP_SET && own_hit |=> pin_out_ff)
    else $error("set-on-compare did not raise the output");

  AST_CMP_CLR: assert property (
    is_cmp && cmp_code == TCC_CMP_CLR && own_hit |=> !pin_out_ff)
    else $error("clear-on-compare did not lower the output");

  AST_CMP_TOG: assert property (
    is_cmp && cmp_code == TCC_CMP_TOG && own_hit
      |=> pin_out_ff != $past(pin_out_ff))
    else $error("toggle-on-compare did not invert the output");

  AST_PAIR_CLR: assert property (
    is_cmp && cmp_code == TCC_CMP_PAIR_CS && pair_hit && !own_hit
      |=> !pin_out_ff)
    else $error("paired code did not clear on ch0 match");

  AST_NO_CAP: assert property (
    cap_sel == TCC_CAP_NONE || is_cmp |-> !cap_evt)
    else $error("capture fired while disabled");

  AST_RISE_CAP: assert property (
    !is_cmp && cap_sel == TCC_CAP_RISE && !pin_in ##1 pin_in |-> cap_evt)
    else $error("rising edge not captured");

endmodule : tcc_chan
`default_nettype wire

// [tcc_counter.sv]
// 16-bit counter with stop, free-running, modulo and up/down modes
`timescale 1ns/1ns
`default_nettype none
module tcc_counter
  import tcc_pkg::*;
#(
  parameter int W = TCC_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode,
  input wire logic [W-1:0] top,
  output logic [W-1:0] count_ff,
  output logic down_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // next value; down_ff tells the direction of the step that gave count_ff
  logic [W-1:0] nxt_count;
  logic nxt_down;
  wire at_top = (count_ff >= top);
  wire at_zero = (count_ff == {W{1'b0}});
  wire turn_down = ~down_ff & at_top;  // up/down: top reached going up
  wire turn_up = down_ff & at_zero;    // up/down: zero reached going down

  always_comb begin
    nxt_count = count_ff;
    nxt_down = down_ff;
    case (tcc_mode_t'(mode))
      TCC_MODE_STOP: begin
        nxt_count = count_ff; // suspended, value held
      end
      TCC_MODE_FREE: begin
        nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
        nxt_down = 1'b0;
      end
      TCC_MODE_MOD: begin
        // wrap from the ch0 compare value back to zero
        nxt_count = at_top ? {W{1'b0}} : count_ff + {{(W-1){1'b0}}, 1'b1};
        nxt_down = 1'b0;
      end
      TCC_MODE_UPDN: begin
        // up to the ch0 compare value, then back down to zero
        if (turn_down) begin
          nxt_down = 1'b1;
          nxt_count = at_zero ? count_ff
                              : count_ff - {{(W-1){1'b0}}, 1'b1};
        end else if (turn_up || ~down_ff) begin
          nxt_down = 1'b0;
          nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
        end else begin
          nxt_count = count_ff - {{(W-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        nxt_count = count_ff;
      end
    endcase
  end

  // counter state; a tick on every clock since the prescaler is not here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= {W{1'b0}};
      down_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      down_ff <= nxt_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_top_going_up;
    mode == TCC_MODE_UPDN && !down_ff && count_ff == top && top != '0;
  endsequence

  AST_MOD_WRAP: assert property (
    mode == TCC_MODE_MOD && count_ff >= top |=> count_ff == '0)
    else $error("modulo counter did not wrap to zero");

  AST_UPDN_TURN: assert property (
    s_top_going_up ##1 mode == TCC_MODE_UPDN
      |-> down_ff && count_ff == $past(top) - 1'b1)
    else $error("up/down counter did not turn at the top");

endmodule : tcc_counter
`default_nettype wire

// [tcc_pin_model.sv]
// model of the external drivers on the channel input pins
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] want,
  output logic [1:0] cc_in
);
  // pins move one edge after the request, low while in reset
  always_ff @(posedge aclk) begin
    cc_in <= aresetn ? want : 2'h0;
  end
endmodule : tcc_pin_model
`default_nettype wire

// [tcc_pkg.sv]
// package of offsets, field layouts, codes and reset values for the block
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int TCC_ADDR_W = 12; // byte address width on the bus
  localparam int TCC_DATA_W = 32; // bus data width
  localparam int TCC_CNT_W = 16;  // counter and value width

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] TCC_IDX_CH0_CMP = 8'hDA;  // ch0_compare_value
  localparam logic [7:0] TCC_IDX_CH1_LO = 8'hDC;   // ch1_value_low
  localparam logic [7:0] TCC_IDX_CH1_HI = 8'hDD;   // ch1_value_high
  localparam logic [7:0] TCC_IDX_CH2_LO = 8'hDE;   // ch2 value low byte
  localparam logic [7:0] TCC_IDX_CH2_HI = 8'hDF;   // ch2_value_high
  localparam logic [7:0] TCC_IDX_COUNT = 8'hE2;    // counter readback
  localparam logic [7:0] TCC_IDX_TCTL = 8'hE4;     // mode and flags
  localparam logic [7:0] TCC_IDX_CH1_CTL = 8'hE6;  // ch1_control
  localparam logic [7:0] TCC_IDX_CH2_CTL = 8'hE7;  // ch2_control

  ////////////////////////////////////////////////////////////////////////////
  // channel control field layout
  localparam int TCC_CTL_RSVD_BIT = 7;  // reserved, software writes 0
  localparam int TCC_CTL_IM_BIT = 6;    // irq_mask
  localparam int TCC_CTL_CMP_LSB = 3;   // compare_action, 3 bits
  localparam int TCC_CTL_FUNC_BIT = 2;  // 0 capture, 1 compare
  localparam int TCC_CTL_CAP_LSB = 0;   // capture_edge_select, 2 bits
  localparam logic [7:0] TCC_CTL_RESET = 8'h40; // only irq_mask set
  localparam logic [7:0] TCC_BYTE_RESET = 8'h00; // value bytes

  ////////////////////////////////////////////////////////////////////////////
  // timer control layout
  localparam int TCC_TCTL_MODE_LSB = 0; // counter mode, 2 bits
  localparam int TCC_FLAG1_BIT = 6;     // ch1_irq_flag
  localparam int TCC_FLAG2_BIT = 7;     // ch2_irq_flag

  // counter operating modes
  typedef enum logic [1:0] {
    TCC_MODE_STOP,
    TCC_MODE_FREE,
    TCC_MODE_MOD,
    TCC_MODE_UPDN
  } tcc_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // compare actions
  localparam logic [2:0] TCC_CMP_SET = 3'h0;
  localparam logic [2:0] TCC_CMP_CLR = 3'h1;
  localparam logic [2:0] TCC_CMP_TOG = 3'h2;
  localparam logic [2:0] TCC_CMP_UPSET = 3'h3;
  localparam logic [2:0] TCC_CMP_UPCLR = 3'h4;
  localparam logic [2:0] TCC_CMP_PAIR_CS = 3'h5; // clear on ch0, set own
  localparam logic [2:0] TCC_CMP_PAIR_SC = 3'h6; // set on ch0, clear own

  // capture edge codes
  localparam logic [1:0] TCC_CAP_NONE = 2'h0;
  localparam logic [1:0] TCC_CAP_RISE = 2'h1;
  localparam logic [1:0] TCC_CAP_FALL = 2'h2;
  localparam logic [1:0] TCC_CAP_BOTH = 2'h3;

  // bus responses
  localparam logic [1:0] TCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCC_RESP_SLVERR = 2'h2;

endpackage : tcc_pkg

// [tcc_timer_cc.sv]
// timer capture/compare channels 1 and 2 with an AXI4-Lite register slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_cc
  import tcc_pkg::*;
#(
  parameter int AW = TCC_ADDR_W,
  parameter int W = TCC_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] cc_in,
  output logic [1:0] cc_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers, shared by the read and write paths
  function automatic logic [7:0] reg_index(input logic [AW-1:0] a);
    return a[9:2];
  endfunction : reg_index

  function automatic logic reg_mapped(input logic [AW-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[AW-1:10] == '0) &&
           (i == TCC_IDX_CH0_CMP || i == TCC_IDX_CH1_LO ||
            i == TCC_IDX_CH1_HI || i == TCC_IDX_CH2_LO ||
            i == TCC_IDX_CH2_HI || i == TCC_IDX_COUNT ||
            i == TCC_IDX_TCTL || i == TCC_IDX_CH1_CTL ||
            i == TCC_IDX_CH2_CTL);
  endfunction : reg_mapped

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ctl_ff [2];     // ch1_control, ch2_control
  logic [W-1:0] val_ff [2];   // ch1/ch2 capture/compare values
  logic [W-1:0] ch0_cmp_ff;   // ch0_compare_value, counter top
  logic [1:0] mode_ff;        // counter mode
  logic [1:0] flag_ff;        // ch1_irq_flag, ch2_irq_flag
  logic [W-1:0] count;        // counter value
  logic down;                 // direction of last counter step
  logic [1:0] cap_evt;        // capture events per channel
  logic [1:0] cmp_evt;        // compare events per channel
  logic [1:0] chan_out;       // pin flip-flops in the channels

  // write channel holding registers
  logic aw_held_ff;
  logic w_held_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  wire [7:0] wr_idx = reg_index(awaddr_ff);
  wire wr_ok = reg_mapped(awaddr_ff);
  wire wr_b0 = wr_fire & wr_ok & wstrb_ff[0];
  wire wr_b1 = wr_fire & wr_ok & wstrb_ff[1];
  wire [7:0] wbyte = wdata_ff[7:0];
  wire wr_tctl = wr_b0 & (wr_idx == TCC_IDX_TCTL);
  wire [1:0] wr_ctl = {wr_b0 & (wr_idx == TCC_IDX_CH2_CTL),
                       wr_b0 & (wr_idx == TCC_IDX_CH1_CTL)};
  wire [1:0] wr_lo = {wr_b0 & (wr_idx == TCC_IDX_CH2_LO),
                      wr_b0 & (wr_idx == TCC_IDX_CH1_LO)};
  wire [1:0] wr_hi = {wr_b0 & (wr_idx == TCC_IDX_CH2_HI),
                      wr_b0 & (wr_idx == TCC_IDX_CH1_HI)};
  wire wr_ch0 = wr_fire & wr_ok & (wr_idx == TCC_IDX_CH0_CMP);
  // writing zero clears a flag, writing one leaves it
  wire [1:0] flag_clr = {wr_tctl & ~wbyte[TCC_FLAG2_BIT],
                         wr_tctl & ~wbyte[TCC_FLAG1_BIT]};
  // a new event beats a clear in the same cycle
  wire [1:0] nxt_flag = cap_evt | cmp_evt | (flag_ff & ~flag_clr);
  wire [1:0] im = {ctl_ff[1][TCC_CTL_IM_BIT], ctl_ff[0][TCC_CTL_IM_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_idx = reg_index(s_axi_araddr);
  wire rd_ok = reg_mapped(s_axi_araddr);
  wire [7:0] rd_tctl = {flag_ff[1], flag_ff[0], 4'h0, mode_ff};
  wire [31:0] rd_word =
    (rd_idx == TCC_IDX_CH0_CMP) ? {16'h0000, ch0_cmp_ff} :
    (rd_idx == TCC_IDX_CH1_LO) ? {24'h000000, val_ff[0][7:0]} :
    (rd_idx == TCC_IDX_CH1_HI) ? {24'h000000, val_ff[0][15:8]} :
    (rd_idx == TCC_IDX_CH2_LO) ? {24'h000000, val_ff[1][7:0]} :
    (rd_idx == TCC_IDX_CH2_HI) ? {24'h000000, val_ff[1][15:8]} :
    (rd_idx == TCC_IDX_COUNT) ? {16'h0000, count} :
    (rd_idx == TCC_IDX_TCTL) ? {24'h000000, rd_tctl} :
    (rd_idx == TCC_IDX_CH1_CTL) ? {24'h000000, ctl_ff[0]} :
    (rd_idx == TCC_IDX_CH2_CTL) ? {24'h000000, ctl_ff[1]} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // write address/data capture; either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // each ready while its own channel holds nothing and no response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_ff & ~aw_take & ~s_axi_bvalid & ~wr_fire;
      s_axi_wready <= ~w_held_ff & ~w_take & ~s_axi_bvalid & ~wr_fire;
    end
  end

  // write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path: one read at a time, data registered with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TCC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_word : 32'h00000000;
        s_axi_rresp <= rd_ok ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer control and ch0 compare value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= TCC_MODE_STOP;
      ch0_cmp_ff <= '0;
      flag_ff <= 2'h0;
    end else begin
      if (wr_tctl) mode_ff <= wbyte[TCC_TCTL_MODE_LSB +: 2];
      if (wr_ch0 && wstrb_ff[0]) ch0_cmp_ff[7:0] <= wbyte;
      if (wr_ch0 && wr_b1) ch0_cmp_ff[15:8] <= wdata_ff[15:8];
      flag_ff <= nxt_flag;
    end
  end

  // interrupt: any flag whose irq_mask is set
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(nxt_flag & im);
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel registers and logic
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      // control stored as written, reserved bit too
      always_ff @(posedge aclk) begin
        if (!aresetn) ctl_ff[g] <= TCC_CTL_RESET;
        else if (wr_ctl[g]) ctl_ff[g] <= wbyte;
      end

      // value bytes; a capture outranks a software write
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          val_ff[g] <= {TCC_BYTE_RESET, TCC_BYTE_RESET};
        end else if (cap_evt[g]) begin
          val_ff[g] <= count;
        end else begin
          if (wr_lo[g]) val_ff[g][7:0] <= wbyte;
          if (wr_hi[g]) val_ff[g][15:8] <= wbyte;
        end
      end

      tcc_chan #(.W(W)) u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .ctl(ctl_ff[g]),
        .count(count),
        .value(val_ff[g]),
        .pair_value(ch0_cmp_ff),
        .running(mode_ff != TCC_MODE_STOP),
        .updown(mode_ff == TCC_MODE_UPDN),
        .down(down),
        .pin_in(cc_in[g]),
        .pin_out_ff(chan_out[g]),
        .cap_evt(cap_evt[g]),
        .cmp_evt(cmp_evt[g])
      );
    end
  endgenerate

  assign cc_out = chan_out;

  // shared counter, its top is the ch0 compare value
  tcc_counter #(.W(W)) u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode_ff),
    .top(ch0_cmp_ff),
    .count_ff(count),
    .down_ff(down)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_IRQ_GATED: assert property (
    (nxt_flag & im) == 2'h0 |=> !irq)
    else $error("interrupt raised with no unmasked flag");

  AST_CTL_RESET: assert property (
    $rose(aresetn) |-> ctl_ff[0] == TCC_CTL_RESET &&
                       ctl_ff[1] == TCC_CTL_RESET)
    else $error("control register reset value wrong");

  AST_CAP_COPY: assert property (
    cap_evt[0] |=> val_ff[0] == $past(count) && flag_ff[0])
    else $error("capture did not copy the counter");

  AST_FLAG_W1: assert property (
    flag_ff[0] && wr_tctl && wbyte[TCC_FLAG1_BIT] |=> flag_ff[0])
    else $error("writing one cleared a flag");

  AST_FLAG_W0: assert property (
    wr_tctl && !wbyte[TCC_FLAG1_BIT] && !cap_evt[0] && !cmp_evt[0]
      |=> !flag_ff[0])
    else $error("writing zero did not clear a flag");

  AST_LO_WRITE: assert property (
    wr_lo[0] && !cap_evt[0] |=> val_ff[0][7:0] == $past(wbyte))
    else $error("value low byte write lost");

endmodule : tcc_timer_cc
`default_nettype wire
